//--- design/tx_seq_host.sv
// host end: resets, configures, calibrates and powers up the transmitter
// assumes the device shares mclk and answers reads one cycle after select
`timescale 1ns/1ps
module tx_seq_host #(
  parameter int TURN_ON_CYCLES = tx_seq_pkg::TURN_ON_CYC,
  parameter int LOCK_CYCLES = tx_seq_pkg::LOCK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link to the device
  tx_seq_if.hst link,
  // user commands
  input wire logic start,
  input wire logic hop,
  input wire logic power_off,
  // user settings, sampled while configuring; prbs_req is sampled at start, user_bit while on
  input wire logic prbs_req,
  input wire logic bypass_req,
  input wire logic [3:0] vco_a,
  input wire logic [3:0] vco_b,
  input wire logic [7:0] pa_bias,
  input wire logic [7:0] rate_div,
  input wire logic user_bit,
  // status
  output logic busy,
  output logic ready,
  output logic pa_on
);

  typedef enum logic [12:0] {
    S_IDLE = 13'h0001, S_RST_LO = 13'h0002, S_RST_HI = 13'h0004,
    S_CFG = 13'h0008, S_CAL = 13'h0010, S_POLL = 13'h0020,
    S_GAP = 13'h0040, S_CHK = 13'h0080, S_PWR_UP = 13'h0100,
    S_WAIT = 13'h0200, S_TX_EN = 13'h0400, S_ON = 13'h0800,
    S_PD = 13'h1000
  } state_t;

  state_t st_q, st_d;
  logic sel_n_q, sel_n_d;
  logic we_q, we_d;
  logic [2:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic txd_q, txd_d;
  logic fs_q, fs_d;
  logic prbs_q, prbs_d;
  logic [2:0] idx_q, idx_d;
  logic [tx_seq_pkg::WAIT_W-1:0] wait_q, wait_d;
  logic pa_q, pa_d;
  logic busy_q, busy_d;
  logic ready_q, ready_d;

  function automatic logic [7:0] main_word(input logic fs, input logic txp,
                                           input logic syp, input logic rfp,
                                           input logic rn);
    logic [7:0] w;
    w = 8'h00;
    w[tx_seq_pkg::MAIN_FSEL_BIT] = fs;
    w[tx_seq_pkg::MAIN_TX_PD_BIT] = txp;
    w[tx_seq_pkg::MAIN_SYN_PD_BIT] = syp;
    w[tx_seq_pkg::MAIN_REF_PD_BIT] = rfp;
    w[tx_seq_pkg::MAIN_RST_N_BIT] = rn;
    return w;
  endfunction

  always_comb begin
    st_d = st_q;
    sel_n_d = 1'b1; // RULE6
    we_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    txd_d = txd_q;
    fs_d = fs_q;
    prbs_d = prbs_q;
    idx_d = idx_q;
    wait_d = wait_q;
    pa_d = pa_q;
    busy_d = st_q != S_IDLE;
    ready_d = st_q == S_ON;
    case (st_q)
      S_IDLE: begin
        if (start) begin
          prbs_d = prbs_req;
          fs_d = 1'b0;
          st_d = S_RST_LO;
        end
      end
      S_RST_LO: begin
        sel_n_d = 1'b0; // RULE7
        we_d = 1'b1;
        addr_d = tx_seq_pkg::ADDR_MAIN;
        wdata_d = main_word(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
        st_d = S_RST_HI;
      end
      S_RST_HI: begin
        sel_n_d = 1'b0;
        we_d = 1'b1;
        addr_d = tx_seq_pkg::ADDR_MAIN;
        wdata_d = main_word(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        idx_d = 3'h0;
        st_d = S_CFG;
      end
      S_CFG: begin
        sel_n_d = 1'b0; // RULE8
        we_d = 1'b1;
        idx_d = idx_q + 3'h1;
        case (idx_q)
          3'h0: begin
            addr_d = tx_seq_pkg::ADDR_INTF;
            wdata_d = {7'h00, bypass_req}; // RULE10
          end
          3'h1: begin
            addr_d = tx_seq_pkg::ADDR_VCO;
            wdata_d = {vco_b, vco_a};
          end
          3'h2: begin
            addr_d = tx_seq_pkg::ADDR_PABUF;
            wdata_d = pa_bias;
          end
          3'h3: begin
            addr_d = tx_seq_pkg::ADDR_RATE;
            wdata_d = rate_div;
          end
          default: begin
            addr_d = tx_seq_pkg::ADDR_MODULATOR_CONFIG_REG;
            wdata_d = {7'h00, prbs_q};
            st_d = S_CAL;
          end
        endcase
      end
      S_CAL: begin
        sel_n_d = 1'b0; // RULE14
        we_d = 1'b1;
        addr_d = tx_seq_pkg::ADDR_CAL;
        wdata_d = 8'h01;
        st_d = S_POLL;
      end
      S_POLL: begin
        sel_n_d = 1'b0;
        addr_d = tx_seq_pkg::ADDR_STATUS;
        st_d = S_GAP;
      end
      S_GAP: st_d = S_CHK;
      S_CHK: begin
        if (link.cfg_rdata[tx_seq_pkg::STAT_CAL_DONE_BIT]) begin
          st_d = S_PWR_UP;
        end else begin
          st_d = S_POLL;
        end
      end
      S_PWR_UP: begin
        sel_n_d = 1'b0;
        we_d = 1'b1;
        addr_d = tx_seq_pkg::ADDR_MAIN;
        wdata_d = main_word(fs_q, 1'b1, 1'b0, 1'b0, 1'b1);
        wait_d = tx_seq_pkg::WAIT_W'(TURN_ON_CYCLES); // RULE1
        st_d = S_WAIT;
      end
      S_WAIT: begin
        if (wait_q == '0) begin
          st_d = S_TX_EN; // RULE15
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      S_TX_EN: begin
        sel_n_d = 1'b0;
        we_d = 1'b1;
        addr_d = tx_seq_pkg::ADDR_MAIN;
        wdata_d = main_word(fs_q, 1'b0, 1'b0, 1'b0, 1'b1);
        pa_d = 1'b1;
        if (prbs_q) begin
          txd_d = ~txd_q; // RULE12
        end
        st_d = S_ON;
      end
      S_ON: begin
        if (!prbs_q) begin
          txd_d = user_bit;
        end
        if (power_off) begin
          st_d = S_PD;
        end else if (hop) begin
          // amplifier off across the hop
          fs_d = ~fs_q;
          pa_d = 1'b0; // RULE15
          sel_n_d = 1'b0;
          we_d = 1'b1;
          addr_d = tx_seq_pkg::ADDR_MAIN;
          wdata_d = main_word(~fs_q, 1'b1, 1'b0, 1'b0, 1'b1);
          wait_d = tx_seq_pkg::WAIT_W'(LOCK_CYCLES); // RULE2
          st_d = S_WAIT;
        end
      end
      S_PD: begin
        sel_n_d = 1'b0;
        we_d = 1'b1;
        addr_d = tx_seq_pkg::ADDR_MAIN;
        wdata_d = main_word(fs_q, 1'b1, 1'b1, 1'b1, 1'b1);
        pa_d = 1'b0;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      sel_n_q <= 1'b1;
      we_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      txd_q <= 1'b0;
      fs_q <= 1'b0;
      prbs_q <= 1'b0;
      idx_q <= 3'h0;
      wait_q <= '0;
      pa_q <= 1'b0;
      busy_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sel_n_q <= sel_n_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      txd_q <= txd_d;
      fs_q <= fs_d;
      prbs_q <= prbs_d;
      idx_q <= idx_d;
      wait_q <= wait_d;
      pa_q <= pa_d;
      busy_q <= busy_d;
      ready_q <= ready_d;
    end
  end

  assign link.cfg_sel_n = sel_n_q;
  assign link.cfg_we = we_q;
  assign link.cfg_addr = addr_q;
  assign link.cfg_wdata = wdata_q;
  assign link.tx_data_in = txd_q;
  assign busy = busy_q;
  assign ready = ready_q;
  assign pa_on = pa_q;

endmodule

//--- design/tx_seq_pkg.sv
// shared constants for the transmitter start-up sequencer pair
// assumes both ends run on the same 125 MHz mclk
package tx_seq_pkg;
  // register offsets on the configuration port
  localparam logic [2:0] ADDR_MAIN = 3'h0;
  localparam logic [2:0] ADDR_INTF = 3'h1;
  localparam logic [2:0] ADDR_VCO = 3'h2;
  localparam logic [2:0] ADDR_PABUF = 3'h3;
  localparam logic [2:0] ADDR_MODULATOR_CONFIG_REG = 3'h4;
  localparam logic [2:0] ADDR_RATE = 3'h5;
  localparam logic [2:0] ADDR_CAL = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;
  // field positions
  localparam int MAIN_RST_N_BIT = 0;
  localparam int MAIN_TX_PD_BIT = 1;
  localparam int MAIN_SYN_PD_BIT = 2;
  localparam int MAIN_REF_PD_BIT = 3;
  localparam int MAIN_FSEL_BIT = 6;
  localparam int INTF_BYPASS_BIT = 0;
  localparam int MODULATOR_CONFIG_REG_PRBS_BIT = 0;
  localparam int CAL_START_BIT = 0;
  localparam int STAT_CAL_DONE_BIT = 0;
  localparam int STAT_CAL_BUSY_BIT = 1;
  localparam int STAT_PRBS_RUN_BIT = 2;
  localparam int VCO_B_LSB = 4;
  // values after reset
  localparam logic [7:0] MAIN_RST = 8'h0f;
  localparam logic [7:0] INTF_RST = 8'h00;
  localparam logic [7:0] VCO_RST = 8'h88;
  localparam logic [7:0] PABUF_RST = 8'h04;
  localparam logic [7:0] MODULATOR_CONFIG_REG_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h0f;
  // pattern generator: nine stages, taps at x^9 and x^5
  localparam logic [8:0] PRBS_SEED = 9'h1ff;
  localparam int PRBS_TAP_HI = 8;
  localparam int PRBS_TAP_LO = 4;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int TURN_ON_US = 3200;
  localparam int LOCK_US = 1300;
  localparam int TURN_ON_CYC = TURN_ON_US * CLK_MHZ;
  localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
  localparam int CAL_CYC = 64;
  localparam int WAIT_W = 19;
  localparam int CAL_W = 8;
endpackage

//--- design/tx_seq_if.sv
// configuration port and data pin between host and transmitter
// assumes both ends are clocked by the same mclk
`timescale 1ns/1ps
interface tx_seq_if (
  input wire logic mclk
);
  logic cfg_sel_n;
  logic cfg_we;
  logic [2:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic tx_data_in;

  modport dev (
    input cfg_sel_n,
    input cfg_we,
    input cfg_addr,
    input cfg_wdata,
    input tx_data_in,
    output cfg_rdata
  );

  modport hst (
    output cfg_sel_n,
    output cfg_we,
    output cfg_addr,
    output cfg_wdata,
    output tx_data_in,
    input cfg_rdata
  );
endinterface

//--- design/tx_seq_dev.sv
// transmitter power, reset, calibration and test pattern control
// assumes the host shares mclk and drives the port one cycle per access
// Functional notes
// RULE1 - host waits turn-on time before transmitting
// RULE2 - host waits lock time after set switch
// RULE3 - separate oscillator bias per frequency set
// RULE4 - separate power amplifier buffer bias setting
// RULE5 - independent transmit, synthesizer, oscillator power-downs
// RULE6 - host holds select high during power down
// RULE7 - soft reset bit low restores defaults
// RULE8 - registers writable in any order, then calibrate
// RULE9 - bit timing derived from reference clock
// RULE10 - bypass bit set for full-swing clock
// RULE11 - pattern enable replaces user data
// RULE12 - data pin transition starts the pattern
// RULE13 - nine-stage sequence x^9 + x^5 + 1
// RULE14 - calibration trigger starts automatic calibration
// RULE15 - host keeps amplifier off until locked
`timescale 1ns/1ps
module tx_seq_dev (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link to the host
  tx_seq_if.dev link,
  // power controls
  output logic tx_pd,
  output logic synth_pd,
  output logic refosc_pd,
  // analog settings
  output logic ref_input_bypass,
  output logic [3:0] vco_bias,
  output logic [7:0] pa_buffer_bias,
  output logic freq_sel,
  // modulator side
  output logic mod_data,
  output logic bit_tick,
  output logic cal_busy,
  output logic cal_done
);

  logic [7:0] main_q, main_d;
  logic [7:0] intf_q, intf_d;
  logic [7:0] vco_q, vco_d;
  logic [7:0] pabuf_q, pabuf_d;
  logic [7:0] modulator_config_reg_q, modulator_config_reg_d;
  logic [7:0] rate_q, rate_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] rate_cnt_q, rate_cnt_d;
  logic [tx_seq_pkg::CAL_W-1:0] cal_cnt_q, cal_cnt_d;
  logic cal_busy_q, cal_busy_d;
  logic cal_done_q, cal_done_d;
  logic [8:0] lfsr_q, lfsr_d;
  logic prbs_arm_q, prbs_arm_d;
  logic prbs_run_q, prbs_run_d;
  logic txd_q, txd_d;
  logic txd_prev_q, txd_prev_d;
  logic tick_q, tick_d;
  logic mod_q, mod_d;
  logic vco_sel_q, vco_sel_d;
  logic [3:0] vco_out_q, vco_out_d;
  logic wr;
  logic rd;
  logic held;
  logic prbs_on;

  function automatic logic [7:0] read_mux(input logic [2:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      tx_seq_pkg::ADDR_MAIN: r = main_q;
      tx_seq_pkg::ADDR_INTF: r = intf_q;
      tx_seq_pkg::ADDR_VCO: r = vco_q;
      tx_seq_pkg::ADDR_PABUF: r = pabuf_q;
      tx_seq_pkg::ADDR_MODULATOR_CONFIG_REG: r = modulator_config_reg_q;
      tx_seq_pkg::ADDR_RATE: r = rate_q;
      tx_seq_pkg::ADDR_CAL: r = 8'h00;
      default: begin
        r[tx_seq_pkg::STAT_CAL_DONE_BIT] = cal_done_q;
        r[tx_seq_pkg::STAT_CAL_BUSY_BIT] = cal_busy_q;
        r[tx_seq_pkg::STAT_PRBS_RUN_BIT] = prbs_run_q;
      end
    endcase
    return r;
  endfunction

  assign wr = !link.cfg_sel_n && link.cfg_we;
  assign rd = !link.cfg_sel_n && !link.cfg_we;
  // soft reset stays in force while the bit reads low
  assign held = !main_q[tx_seq_pkg::MAIN_RST_N_BIT];
  assign prbs_on = modulator_config_reg_q[tx_seq_pkg::MODULATOR_CONFIG_REG_PRBS_BIT];

  // configuration registers
  always_comb begin
    main_d = main_q;
    intf_d = intf_q;
    vco_d = vco_q;
    pabuf_d = pabuf_q;
    modulator_config_reg_d = modulator_config_reg_q;
    rate_d = rate_q;
    rdata_d = rdata_q;
    if (wr && link.cfg_addr == tx_seq_pkg::ADDR_MAIN) begin
      main_d = link.cfg_wdata; // RULE5
    end
    if (held) begin
      intf_d = tx_seq_pkg::INTF_RST; // RULE7
      vco_d = tx_seq_pkg::VCO_RST;
      pabuf_d = tx_seq_pkg::PABUF_RST;
      modulator_config_reg_d = tx_seq_pkg::MODULATOR_CONFIG_REG_RST;
      rate_d = tx_seq_pkg::RATE_RST;
    end else if (wr) begin
      // any register may be written in any order once the soft reset bit is high
      case (link.cfg_addr) // RULE8
        tx_seq_pkg::ADDR_INTF: intf_d = link.cfg_wdata;
        tx_seq_pkg::ADDR_VCO: vco_d = link.cfg_wdata;
        tx_seq_pkg::ADDR_PABUF: pabuf_d = link.cfg_wdata;
        tx_seq_pkg::ADDR_MODULATOR_CONFIG_REG: modulator_config_reg_d = link.cfg_wdata;
        tx_seq_pkg::ADDR_RATE: rate_d = link.cfg_wdata;
        default: ;
      endcase
    end
    if (rd) begin
      rdata_d = read_mux(link.cfg_addr);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      main_q <= tx_seq_pkg::MAIN_RST;
      intf_q <= tx_seq_pkg::INTF_RST;
      vco_q <= tx_seq_pkg::VCO_RST;
      pabuf_q <= tx_seq_pkg::PABUF_RST;
      modulator_config_reg_q <= tx_seq_pkg::MODULATOR_CONFIG_REG_RST;
      rate_q <= tx_seq_pkg::RATE_RST;
      rdata_q <= 8'h00;
    end else begin
      main_q <= main_d;
      intf_q <= intf_d;
      vco_q <= vco_d;
      pabuf_q <= pabuf_d;
      modulator_config_reg_q <= modulator_config_reg_d;
      rate_q <= rate_d;
      rdata_q <= rdata_d;
    end
  end

  // calibration; a new trigger during a run restarts it
  always_comb begin
    cal_cnt_d = cal_cnt_q;
    cal_busy_d = cal_busy_q;
    cal_done_d = cal_done_q;
    if (held) begin
      cal_cnt_d = '0;
      cal_busy_d = 1'b0;
      cal_done_d = 1'b0;
    end else if (wr && link.cfg_addr == tx_seq_pkg::ADDR_CAL &&
                 link.cfg_wdata[tx_seq_pkg::CAL_START_BIT]) begin
      cal_cnt_d = tx_seq_pkg::CAL_W'(tx_seq_pkg::CAL_CYC); // RULE14
      cal_busy_d = 1'b1;
      cal_done_d = 1'b0;
    end else if (cal_busy_q) begin
      cal_cnt_d = cal_cnt_q - 1'b1;
      if (cal_cnt_q == tx_seq_pkg::CAL_W'(1)) begin
        cal_busy_d = 1'b0;
        cal_done_d = 1'b1; // RULE14
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_cnt_q <= '0;
      cal_busy_q <= 1'b0;
      cal_done_q <= 1'b0;
    end else begin
      cal_cnt_q <= cal_cnt_d;
      cal_busy_q <= cal_busy_d;
      cal_done_q <= cal_done_d;
    end
  end

  // bit timing and test pattern
  always_comb begin
    rate_cnt_d = rate_cnt_q;
    tick_d = 1'b0;
    txd_d = link.tx_data_in;
    txd_prev_d = txd_q;
    lfsr_d = lfsr_q;
    prbs_arm_d = prbs_arm_q;
    prbs_run_d = prbs_run_q;
    // no reference, no bit timing
    if (main_q[tx_seq_pkg::MAIN_REF_PD_BIT]) begin
      rate_cnt_d = 8'h00;
    end else if (rate_cnt_q >= rate_q) begin
      rate_cnt_d = 8'h00; // RULE9
      tick_d = 1'b1;
    end else begin
      rate_cnt_d = rate_cnt_q + 8'h01;
    end
    if (!prbs_on) begin
      prbs_arm_d = 1'b0;
      prbs_run_d = 1'b0;
    end else if (!prbs_arm_q && !prbs_run_q) begin
      prbs_arm_d = 1'b1;
    end else if (prbs_arm_q && txd_q != txd_prev_q) begin
      prbs_arm_d = 1'b0; // RULE12
      prbs_run_d = 1'b1;
      lfsr_d = tx_seq_pkg::PRBS_SEED;
    end else if (prbs_run_q && tick_q) begin
      lfsr_d = {lfsr_q[7:0], lfsr_q[tx_seq_pkg::PRBS_TAP_HI] ^
                lfsr_q[tx_seq_pkg::PRBS_TAP_LO]}; // RULE13
    end
    mod_d = prbs_run_q ? lfsr_q[tx_seq_pkg::PRBS_TAP_HI] : txd_q; // RULE11
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rate_cnt_q <= 8'h00;
      tick_q <= 1'b0;
      txd_q <= 1'b0;
      txd_prev_q <= 1'b0;
      lfsr_q <= tx_seq_pkg::PRBS_SEED;
      prbs_arm_q <= 1'b0;
      prbs_run_q <= 1'b0;
      mod_q <= 1'b0;
    end else begin
      rate_cnt_q <= rate_cnt_d;
      tick_q <= tick_d;
      txd_q <= txd_d;
      txd_prev_q <= txd_prev_d;
      lfsr_q <= lfsr_d;
      prbs_arm_q <= prbs_arm_d;
      prbs_run_q <= prbs_run_d;
      mod_q <= mod_d;
    end
  end

  // bias follows the selected frequency set
  always_comb begin
    vco_sel_d = main_q[tx_seq_pkg::MAIN_FSEL_BIT];
    vco_out_d = main_q[tx_seq_pkg::MAIN_FSEL_BIT] ?
      vco_q[tx_seq_pkg::VCO_B_LSB +: 4] : vco_q[3:0]; // RULE3
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vco_sel_q <= 1'b0;
      vco_out_q <= tx_seq_pkg::VCO_RST[3:0];
    end else begin
      vco_sel_q <= vco_sel_d;
      vco_out_q <= vco_out_d;
    end
  end

  assign link.cfg_rdata = rdata_q;
  assign tx_pd = main_q[tx_seq_pkg::MAIN_TX_PD_BIT]; // RULE5
  assign synth_pd = main_q[tx_seq_pkg::MAIN_SYN_PD_BIT];
  assign refosc_pd = main_q[tx_seq_pkg::MAIN_REF_PD_BIT];
  // the bypass only switches the input stage; the host picks it per source
  assign ref_input_bypass = intf_q[tx_seq_pkg::INTF_BYPASS_BIT]; // RULE10
  assign vco_bias = vco_out_q;
  assign pa_buffer_bias = pabuf_q; // RULE4
  assign freq_sel = vco_sel_q;
  assign mod_data = mod_q;
  assign bit_tick = tick_q;
  assign cal_busy = cal_busy_q;
  assign cal_done = cal_done_q;

endmodule

//--- verification/tx_seq_link_sva.sv
// link checker for the host and transmitter configuration port
// assumes it sits beside the interface, one mclk domain
`timescale 1ns/1ps
module tx_seq_link_sva #(
  parameter int TURN_ON_CYCLES = 20,
  parameter int LOCK_CYCLES = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link signals
  input wire logic cfg_sel_n,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic tx_data_in
);
  localparam int W_LO = LOCK_CYCLES;
  localparam int W_HI = TURN_ON_CYCLES + 4;
  logic wr, main_wr, tx_en_wr, pwr_wr, cal_wr, rd7, rst_lo, hop_q;
  logic [19:0] since_q, since_d;
  logic [7:0] cal_q, cal_d, main_q, main_d;
  logic fsel_old_q, fsel_old_d, prbs_q, prbs_d;
  assign wr = !cfg_sel_n && cfg_we;
  assign main_wr = wr && cfg_addr == tx_seq_pkg::ADDR_MAIN;
  assign tx_en_wr = main_wr && !cfg_wdata[tx_seq_pkg::MAIN_TX_PD_BIT];
  // synth and oscillator on, amplifier still off
  assign pwr_wr = main_wr && cfg_wdata[3:0] == 4'h3;
  assign cal_wr = wr && cfg_addr == tx_seq_pkg::ADDR_CAL && cfg_wdata[0];
  assign rd7 = !cfg_sel_n && !cfg_we && cfg_addr == tx_seq_pkg::ADDR_STATUS;
  assign rst_lo = main_wr && !cfg_wdata[0];
  assign hop_q = main_q[tx_seq_pkg::MAIN_FSEL_BIT] != fsel_old_q;
  always_comb begin
    since_d = (since_q == '1) ? since_q : since_q + 20'h1;
    cal_d = (cal_q == '1) ? cal_q : cal_q + 8'h1;
    main_d = main_q;
    fsel_old_d = fsel_old_q;
    prbs_d = prbs_q;
    if (main_wr) begin
      since_d = 20'h1;
      main_d = cfg_wdata;
      fsel_old_d = main_q[tx_seq_pkg::MAIN_FSEL_BIT];
    end
    if (cal_wr) begin
      cal_d = 8'h0;
    end
    if (wr && cfg_addr == tx_seq_pkg::ADDR_MODULATOR_CONFIG_REG) begin
      prbs_d = cfg_wdata[tx_seq_pkg::MODULATOR_CONFIG_REG_PRBS_BIT];
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      since_q <= '1;
      cal_q <= '1;
      main_q <= tx_seq_pkg::MAIN_RST;
      fsel_old_q <= 1'b0;
      prbs_q <= 1'b0;
    end else begin
      since_q <= since_d;
      cal_q <= cal_d;
      main_q <= main_d;
      fsel_old_q <= fsel_old_d;
      prbs_q <= prbs_d;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_release;
    ##[1:3] (main_wr && cfg_wdata[0]);
  endsequence
  sequence s_calibrate;
    ##[1:8] cal_wr;
  endsequence
  a_reset_release: assert property (rst_lo |-> s_release)
    else $error("soft reset not released");
  a_config_cal: assert property (
    rst_lo |-> s_release ##0 s_calibrate)
    else $error("calibration not started after configuration");
  a_cal_poll: assert property (cal_wr |-> ##[1:4] rd7)
    else $error("status not polled after calibration start");
  a_cal_status: assert property (
    rd7 && cal_q > 8'h1 && cal_q < 8'h38 |=> cfg_rdata[1:0] == 2'b10)
    else $error("calibration status wrong while running");
  a_cal_finish: assert property (cal_wr |-> ##[64:80] pwr_wr)
    else $error("synthesizer not powered after calibration");
  a_turn_on_wait: assert property (
    tx_en_wr |-> since_q >= (hop_q ? LOCK_CYCLES : TURN_ON_CYCLES))
    else $error("transmit enabled before lock time");
  a_lock_bound: assert property (pwr_wr |-> ##[W_LO:W_HI] tx_en_wr)
    else $error("transmit not enabled after lock wait");
  a_pa_safe: assert property (tx_en_wr |-> cfg_wdata[3:0] == 4'h1)
    else $error("transmit enabled with synthesizer off");
  a_prbs_kick: assert property (
    tx_en_wr && prbs_q && !hop_q |-> ##[0:3] $changed(tx_data_in))
    else $error("no data pin edge after pattern enable");
  a_rdata_hold: assert property (
    !(!cfg_sel_n && !cfg_we) |=> $stable(cfg_rdata))
    else $error("read data changed without a read");
endmodule

//--- verification/tx_power_sequencer_control_test.sv
// bench: host end and transmitter end joined by the link interface
// assumes shortened turn-on and lock waits set by parameters here
`timescale 1ns/1ps
module tx_power_sequencer_control_test;
  localparam int TON = 20;
  localparam int LCK = 10;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0, hop = 1'b0, power_off = 1'b0;
  logic prbs_req = 1'b0, bypass_req = 1'b0, user_bit = 1'b0;
  logic [3:0] vco_a = 4'h3, vco_b = 4'hc;
  logic [7:0] pa_bias = 8'h5a, rate_div = 8'h02;
  logic busy, ready, pa_on, tx_pd, synth_pd, refosc_pd, ref_input_bypass;
  logic freq_sel, mod_data, bit_tick, cal_busy, cal_done;
  logic [3:0] vco_bias;
  logic [7:0] pa_buffer_bias, flags;
  int n_errors = 0;
  int checks_done = 0;
  assign flags = {tx_pd, synth_pd, refosc_pd, ref_input_bypass, freq_sel,
    cal_busy, cal_done, pa_on};
  always #4 mclk = ~mclk;
  tx_seq_if tx_seq_if_inst (.mclk(mclk));
  tx_seq_host #(.TURN_ON_CYCLES(TON), .LOCK_CYCLES(LCK)) tx_seq_host_inst (
    .mclk(mclk), .rst_n(rst_n), .link(tx_seq_if_inst.hst), .start(start),
    .hop(hop), .power_off(power_off), .prbs_req(prbs_req),
    .bypass_req(bypass_req), .vco_a(vco_a), .vco_b(vco_b),
    .pa_bias(pa_bias), .rate_div(rate_div), .user_bit(user_bit),
    .busy(busy), .ready(ready), .pa_on(pa_on));
  tx_seq_dev tx_seq_dev_inst (
    .mclk(mclk), .rst_n(rst_n), .link(tx_seq_if_inst.dev), .tx_pd(tx_pd),
    .synth_pd(synth_pd), .refosc_pd(refosc_pd),
    .ref_input_bypass(ref_input_bypass), .vco_bias(vco_bias),
    .pa_buffer_bias(pa_buffer_bias), .freq_sel(freq_sel),
    .mod_data(mod_data), .bit_tick(bit_tick), .cal_busy(cal_busy),
    .cal_done(cal_done));
  tx_seq_link_sva #(.TURN_ON_CYCLES(TON), .LOCK_CYCLES(LCK))
    tx_seq_link_sva_inst (
    .mclk(mclk), .rst_n(rst_n), .cfg_sel_n(tx_seq_if_inst.cfg_sel_n),
    .cfg_we(tx_seq_if_inst.cfg_we), .cfg_addr(tx_seq_if_inst.cfg_addr),
    .cfg_wdata(tx_seq_if_inst.cfg_wdata),
    .cfg_rdata(tx_seq_if_inst.cfg_rdata),
    .tx_data_in(tx_seq_if_inst.tx_data_in));
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_min(input int got, input int lim);
    checks_done++;
    if (got < lim) begin
      n_errors++;
      $display("FAIL at %0t: gap %h below %h", $time, got, lim);
    end
  endtask
  task automatic t_defaults();
    chk(flags, 8'he0);
    chk(pa_buffer_bias, tx_seq_pkg::PABUF_RST);
    chk({4'h0, vco_bias}, {4'h0, tx_seq_pkg::VCO_RST[3:0]});
  endtask
  task automatic t_power_up(input logic bp, input logic pr);
    int ts, tt, n;
    logic seen;
    bypass_req = bp;
    prbs_req = pr;
    start = 1'b1;
    ts = 0;
    tt = 0;
    seen = 1'b0;
    // run until the amplifier stage is really powered, one edge after pa_on
    for (n = 1; n < 400 && tt == 0; n++) begin
      tick();
      if (busy === 1'b1) start = 1'b0;
      if (cal_busy === 1'b1) seen = 1'b1;
      if (synth_pd === 1'b0 && ts == 0) ts = n;
      if (tx_pd === 1'b0 && tt == 0) tt = n;
    end
    repeat (2) tick();
    chk({7'h0, seen}, 8'h01);
    chk_min(tt - ts, TON);
    chk(flags, {3'h0, bp, 4'h3});
    chk({7'h0, ready}, 8'h01);
    chk(pa_buffer_bias, pa_bias);
    chk({4'h0, vco_bias}, {4'h0, vco_a});
  endtask
  task automatic t_user();
    user_bit = 1'b1;
    repeat (4) tick();
    chk({7'h0, mod_data}, 8'h01);
    user_bit = 1'b0;
    repeat (4) tick();
    chk({7'h0, mod_data}, 8'h00);
  endtask
  task automatic t_hop();
    int t1, t0, n;
    logic f;
    f = freq_sel;
    hop = 1'b1;
    t1 = 0;
    t0 = 0;
    for (n = 1; n < 200 && t0 == 0; n++) begin
      tick();
      if (pa_on === 1'b0) hop = 1'b0;
      if (tx_pd === 1'b1 && t1 == 0) t1 = n;
      if (tx_pd === 1'b0 && t1 != 0) t0 = n;
    end
    repeat (2) tick();
    chk_min(t0 - t1, LCK);
    chk({7'h0, freq_sel}, {7'h0, ~f});
    chk({4'h0, vco_bias}, {4'h0, f ? vco_a : vco_b});
  endtask
  task automatic t_power_off();
    int n;
    power_off = 1'b1;
    for (n = 0; n < 50 && busy !== 1'b0; n++) tick();
    power_off = 1'b0;
    repeat (2) tick();
    chk(flags & 8'he1, 8'he0);
    chk({7'h0, tx_seq_if_inst.cfg_sel_n}, 8'h01);
  endtask
  task automatic t_prbs();
    logic [8:0] lfsr;
    logic [39:0] exp_bits;
    logic [15:0] got;
    int n, k, prev, gap;
    lfsr = tx_seq_pkg::PRBS_SEED;
    for (k = 0; k < 40; k++) begin
      exp_bits[k] = lfsr[8];
      lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
    end
    k = 0;
    prev = 0;
    gap = 0;
    repeat (4) tick();
    for (n = 1; n < 400 && k < 16; n++) begin
      tick();
      if (bit_tick === 1'b1) begin
        if (prev != 0) gap = n - prev;
        prev = n;
        got[k] = mod_data;
        k++;
      end
    end
    chk(8'(gap), rate_div + 8'h1);
    k = 0;
    for (n = 0; n < 17; n++) if (got === exp_bits[n +: 16]) k = n;
    chk(got[7:0], exp_bits[k +: 8]);
    chk(got[15:8], exp_bits[k + 8 +: 8]);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    tick();
    t_defaults();
    t_power_up(1'b1, 1'b0);
    t_user();
    t_hop();
    t_power_off();
    // second start with new settings after the power down
    pa_bias = 8'ha5;
    t_power_up(1'b0, 1'b1);
    t_prbs();
    conclude();
  end
endmodule
